// [src/acps_defs.vh]
// Purpose: constants for the converter control and pin select block
// Assumes: register byte address is four times the register index
// Notes:   definitions only
`ifndef ACPS_DEFS_VH
`define ACPS_DEFS_VH

// register indices as printed, byte address = index * 4
`define ACPS_IDX_NARROW      8'h00
`define ACPS_IDX_WIDE        8'h01
`define ACPS_IDX_PINSEL      8'h08
`define ACPS_ADDR_W          8

// narrow converter register fields
`define ACPS_N_RSVD_BIT      7
`define ACPS_N_RATE_HI       6
`define ACPS_N_RATE_LO       5
`define ACPS_N_SEL_HI        4
`define ACPS_N_SEL_LO        3
`define ACPS_N_DATA_HI       2
`define ACPS_N_DATA_LO       0
`define ACPS_N_DW            3

// wide converter register fields
`define ACPS_W_RATE_HI       7
`define ACPS_W_RATE_LO       6
`define ACPS_W_SEL_HI        5
`define ACPS_W_SEL_LO        4
`define ACPS_W_DATA_HI       3
`define ACPS_W_DATA_LO       0
`define ACPS_W_DW            4

// pin select field: bits 5..2, one per multiplexed pin
`define ACPS_PS_LO           2
`define ACPS_PS_HI           5
`define ACPS_PS_N            4

// rate encodings
`define ACPS_RATE_OFF        2'h0
`define ACPS_RATE_DIV2       2'h1
`define ACPS_RATE_DIV3       2'h2
`define ACPS_RATE_DIV4       2'h3

// reset values
`define ACPS_RST_RATE        2'h0
`define ACPS_RST_SEL         2'h0
`define ACPS_RST_PINSEL      8'h00
`define ACPS_RST_N_DATA      3'h0
`define ACPS_RST_W_DATA      4'h0

// axi responses
`define ACPS_RESP_OKAY       2'h0
`define ACPS_RESP_SLVERR     2'h2

`endif

// [src/acps_conv.v]
// Purpose: one converter channel: rate divider, input selector, result
// Assumes: analog levels arrive as already quantised words on pins
// Notes:   software may write the result; a conversion in the same cycle wins
`timescale 1ns/1ps
`default_nettype none
`include "acps_defs.vh"

module acps_conv #(
    parameter DW = 4
) (
    input  wire            aclk,
    input  wire            aresetn,
    input  wire            wr_en,
    input  wire [1:0]      wr_rate,
    input  wire [1:0]      wr_sel,
    input  wire [DW-1:0]   wr_data,
    input  wire [4*DW-1:0] ain,
    output reg  [1:0]      rate,
    output reg  [1:0]      sel,
    output reg  [DW-1:0]   data,
    output reg             conv_done
);
    reg  [4*DW-1:0] ain_meta;
    reg  [4*DW-1:0] ain_sync;
    reg  [1:0]      cnt;
    wire            tick;

    // two flops before anything reads the pins
    always @(posedge aclk) begin
        ain_meta <= ain;
        ain_sync <= ain_meta;
    end

    // period is rate+1 clocks: 01 -> /2, 10 -> /3, 11 -> /4
    assign tick = (rate != `ACPS_RATE_OFF) && (cnt == rate);

    always @(posedge aclk) begin
        if (!aresetn) begin
            rate      <= `ACPS_RST_RATE;
            sel       <= `ACPS_RST_SEL;
            data      <= {DW{1'b0}};
            cnt       <= 2'h0;
            conv_done <= 1'b0;
        end else begin
            conv_done <= tick;
            if (wr_en) begin
                rate <= wr_rate;
                sel  <= wr_sel;
            end
            if (rate == `ACPS_RATE_OFF || tick || wr_en) begin
                cnt <= 2'h0; // a new setting restarts the divider
            end else begin
                cnt <= cnt + 2'h1;
            end
            if (tick) begin
                data <= ain_sync[sel*DW +: DW];
            end else if (wr_en) begin
                data <= wr_data; // off: only software moves it
            end
        end
    end
endmodule
`default_nettype wire

// [src/acps_top.v]
// Purpose: converter control/result registers and port pin function select
// Assumes: AXI4-Lite slave, one write and one read outstanding at most
// Notes:   only byte lane 0 carries register data; upper bits read as zero
`timescale 1ns/1ps
`default_nettype none
`include "acps_defs.vh"

module acps_top #(
    parameter NDW = `ACPS_N_DW,
    parameter WDW = `ACPS_W_DW
) (
    input  wire                aclk,
    input  wire                aresetn,
    input  wire [31:0]         s_axi_awaddr,
    input  wire                s_axi_awvalid,
    output wire                s_axi_awready,
    input  wire [31:0]         s_axi_wdata,
    input  wire [3:0]          s_axi_wstrb,
    input  wire                s_axi_wvalid,
    output wire                s_axi_wready,
    output reg  [1:0]          s_axi_bresp,
    output reg                 s_axi_bvalid,
    input  wire                s_axi_bready,
    input  wire [31:0]         s_axi_araddr,
    input  wire                s_axi_arvalid,
    output wire                s_axi_arready,
    output reg  [31:0]         s_axi_rdata,
    output reg  [1:0]          s_axi_rresp,
    output reg                 s_axi_rvalid,
    input  wire                s_axi_rready,
    input  wire [4*NDW-1:0]    narrow_ain,
    input  wire [4*WDW-1:0]    wide_ain,
    input  wire [3:0]          pwm_out,
    input  wire [3:0]          gpio_out,
    input  wire [3:0]          gpio_oe,
    input  wire [3:0]          mux_pin_i,
    output wire [3:0]          mux_pin_o,
    output wire [3:0]          mux_pin_oe,
    output wire [3:0]          gpio_in,
    output wire [3:0]          pin_is_gpio,
    output wire                narrow_conv_done,
    output wire                wide_conv_done
);
    localparam [1:0] DEC_NARROW = 2'h0;
    localparam [1:0] DEC_WIDE   = 2'h1;
    localparam [1:0] DEC_PINSEL = 2'h2;
    localparam [1:0] DEC_NONE   = 2'h3;

    reg  [31:0]      aw_addr;
    reg              aw_held;
    reg  [7:0]       w_byte;
    reg              w_lane0;
    reg              w_held;
    reg  [7:0]       pinsel;
    reg  [3:0]       pin_meta;
    reg  [3:0]       pin_sync;
    wire             do_write;
    wire [1:0]       wr_dec;
    wire             wr_ok;
    wire [1:0]       rd_dec;
    wire [1:0]       n_rate;
    wire [1:0]       n_sel;
    wire [NDW-1:0]   n_data;
    wire [1:0]       w_rate;
    wire [1:0]       w_sel;
    wire [WDW-1:0]   w_data;
    wire [3:0]       ps_bits;
    reg  [7:0]       rd_byte;

    // byte address must be word aligned and equal to four times the index
    function [1:0] acps_decode;
        input [31:0] addr;
        begin
            if (addr[1:0] != 2'h0 || addr[31:10] != 22'h0) begin
                acps_decode = DEC_NONE;
            end else if (addr[9:2] == `ACPS_IDX_NARROW) begin
                acps_decode = DEC_NARROW;
            end else if (addr[9:2] == `ACPS_IDX_WIDE) begin
                acps_decode = DEC_WIDE;
            end else if (addr[9:2] == `ACPS_IDX_PINSEL) begin
                acps_decode = DEC_PINSEL;
            end else begin
                acps_decode = DEC_NONE;
            end
        end
    endfunction

    // write path: address and data taken in either order, then one response
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign do_write      = aw_held && w_held && !s_axi_bvalid;
    assign wr_dec        = acps_decode(aw_addr);
    // lane 0 off means nothing to store, yet the write is still answered
    assign wr_ok         = do_write && w_lane0;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr      <= 32'h0;
            aw_held      <= 1'b0;
            w_byte       <= 8'h00;
            w_lane0      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `ACPS_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr <= s_axi_awaddr;
                aw_held <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_byte  <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
                w_held  <= 1'b1;
            end
            if (do_write) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_dec == DEC_NONE) ? `ACPS_RESP_SLVERR : `ACPS_RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // pin function select register
    always @(posedge aclk) begin
        if (!aresetn) begin
            pinsel <= `ACPS_RST_PINSEL; // pulse-width output after reset
        end else if (wr_ok && wr_dec == DEC_PINSEL) begin
            pinsel <= w_byte;
        end
    end

    acps_conv #(
        .DW        (NDW)
    ) u_narrow (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .wr_en     (wr_ok && wr_dec == DEC_NARROW),
        .wr_rate   (w_byte[`ACPS_N_RATE_HI:`ACPS_N_RATE_LO]),
        .wr_sel    (w_byte[`ACPS_N_SEL_HI:`ACPS_N_SEL_LO]),
        .wr_data   (w_byte[`ACPS_N_DATA_HI:`ACPS_N_DATA_LO]),
        .ain       (narrow_ain),
        .rate      (n_rate),
        .sel       (n_sel),
        .data      (n_data),
        .conv_done (narrow_conv_done)
    );

    acps_conv #(
        .DW        (WDW)
    ) u_wide (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .wr_en     (wr_ok && wr_dec == DEC_WIDE),
        .wr_rate   (w_byte[`ACPS_W_RATE_HI:`ACPS_W_RATE_LO]),
        .wr_sel    (w_byte[`ACPS_W_SEL_HI:`ACPS_W_SEL_LO]),
        .wr_data   (w_byte[`ACPS_W_DATA_HI:`ACPS_W_DATA_LO]),
        .ain       (wide_ain),
        .rate      (w_rate),
        .sel       (w_sel),
        .data      (w_data),
        .conv_done (wide_conv_done)
    );

    // pin muxing: select bit 0 = pulse-width, 1 = general I/O
    assign ps_bits     = pinsel[`ACPS_PS_HI:`ACPS_PS_LO];
    assign pin_is_gpio = ps_bits;
    assign mux_pin_o   = (ps_bits & gpio_out) | (~ps_bits & pwm_out);
    assign mux_pin_oe  = (ps_bits & gpio_oe) | ~ps_bits;

    // pin levels come from outside, so two flops before use
    always @(posedge aclk) begin
        pin_meta <= mux_pin_i;
        pin_sync <= pin_meta;
    end
    assign gpio_in = pin_sync & ps_bits;

    // read path: data registered on the same edge that takes the address
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_dec        = acps_decode(s_axi_araddr);

    always @* begin
        case (rd_dec)
            DEC_NARROW: begin
                rd_byte = {1'b1, n_rate, n_sel, n_data}; // bit 7 reads one
            end
            DEC_WIDE: begin
                rd_byte = {w_rate, w_sel, w_data};
            end
            DEC_PINSEL: begin
                rd_byte = pinsel;
            end
            default: begin
                rd_byte = 8'h00;
            end
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= `ACPS_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h0, rd_byte};
            s_axi_rresp  <= (rd_dec == DEC_NONE) ? `ACPS_RESP_SLVERR : `ACPS_RESP_OKAY;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// [test/acps_properties.sv]
// Purpose: port-level properties of the converter and pin select block
// Assumes: byte address is four times the register index
// Notes:   rate shadow lags the register, so the off check waits two cycles
`timescale 1ns/1ps
`default_nettype none
module acps_properties (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic [3:0]  pwm_out,
    input wire logic [3:0]  gpio_out,
    input wire logic [3:0]  gpio_oe,
    input wire logic [3:0]  mux_pin_o,
    input wire logic [3:0]  mux_pin_oe,
    input wire logic [3:0]  pin_is_gpio,
    input wire logic        narrow_conv_done,
    input wire logic        wide_conv_done
);
    logic [31:0] rd_a;
    logic [31:0] wr_a;
    logic [1:0]  wr_r;
    logic        wr_s;
    logic [1:0]  n_rate;
    always @(posedge aclk) begin
        if (!aresetn) begin
            rd_a <= 32'h0;
            n_rate <= 2'h0;
        end else begin
            if (s_axi_arvalid && s_axi_arready) rd_a <= s_axi_araddr;
            if (s_axi_bvalid && s_axi_bready && wr_a == 32'h0 && wr_s) n_rate <= wr_r;
        end
        if (s_axi_awvalid && s_axi_awready) wr_a <= s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready) begin
            wr_r <= s_axi_wdata[6:5];
            wr_s <= s_axi_wstrb[0];
        end
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence n_off;
        n_rate == 2'h0 ##1 n_rate == 2'h0;
    endsequence
    a_pwm_route: assert property ((~pin_is_gpio & ((mux_pin_o ^ pwm_out) | ~mux_pin_oe)) == 4'h0)
        else $error("pulse-width pin routing wrong");
    a_gpio_route: assert property ((pin_is_gpio & ((mux_pin_o ^ gpio_out) | (mux_pin_oe ^ gpio_oe))) == 4'h0)
        else $error("gpio pin routing wrong");
    a_reset_pwm: assert property ($rose(aresetn) |-> pin_is_gpio == 4'h0 && mux_pin_oe == 4'hF)
        else $error("pins not pulse-width after reset");
    a_narrow_top_one: assert property (s_axi_rvalid && rd_a == 32'h0 |-> s_axi_rdata[31:7] == 25'h1)
        else $error("narrow read top bits wrong");
    a_wide_upper_zero: assert property (s_axi_rvalid && rd_a == 32'h4 |-> s_axi_rdata[31:8] == 24'h0)
        else $error("wide read upper bits wrong");
    a_narrow_done_gap: assert property (narrow_conv_done |=> !narrow_conv_done)
        else $error("narrow conversions too close");
    a_wide_done_gap: assert property (wide_conv_done |=> !wide_conv_done)
        else $error("wide conversions too close");
    a_narrow_off_idle: assert property (n_off |-> !narrow_conv_done)
        else $error("narrow converted while off");
endmodule
bind acps_top acps_properties u_acps_properties (.*);
`default_nettype wire

// [test/tb.sv]
// Purpose: register, pin routing and conversion checks over the register bus
// Assumes: byte address is four times the register index
// Notes:   converter inputs are driven as quantised words
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fail_count++; \
    $display("mismatch at %0t got %h exp %h", $time, (a), (e)); end end
module tb;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
    logic [31:0] s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = 4'hF, pwm_out = 4'hA, gpio_out = 4'hF, gpio_oe = 4'h3;
    logic [3:0]  mux_pin_i = 4'hF;
    logic [3:0]  mux_pin_o, mux_pin_oe, gpio_in, pin_is_gpio;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        narrow_conv_done, wide_conv_done;
    logic [11:0] narrow_ain = 12'hD59;
    logic [15:0] wide_ain = 16'h9C52;
    logic [7:0]  nd, wd;
    int          fail_count = 0, total_checks = 0;
    acps_top u_acps_top (.*);
    always #10 aclk = ~aclk;
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // counts conversion pulses over a window of whole clocks
    task automatic count_done(input int cyc);
        nd = 8'h00;
        wd = 8'h00;
        repeat (cyc) begin
            @(posedge aclk);
            nd += narrow_conv_done;
            wd += wide_conv_done;
        end
    endtask
    // waits for the answer as long as it takes; only the watchdog ends a hang
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic chkrd(input logic [31:0] a, input logic [7:0] e, input logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        `CHK(rd, {24'h0, e})
        `CHK(rs, r)
    endtask
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        #1;
        `CHK({pin_is_gpio, mux_pin_oe, mux_pin_o}, {4'h0, 4'hF, 4'hA})
        chkrd(32'h20, 8'h00, 2'h0);
        chkrd(32'h00, 8'h80, 2'h0);
        chkrd(32'h04, 8'h00, 2'h0);
        wr(32'h20, 32'h14);
        repeat (4) @(posedge aclk);
        #1;
        `CHK({pin_is_gpio, mux_pin_o, mux_pin_oe, gpio_in}, {4'h5, 4'hF, 4'hB, 4'h5})
        chkrd(32'h20, 8'h14, 2'h0);
        mux_pin_i <= 4'h6;
        gpio_oe <= 4'h0; // general pins made inputs before input 1 is chosen
        repeat (3) @(posedge aclk);
        #1;
        `CHK({gpio_in, mux_pin_oe}, {4'h4, 4'hA})
        // every dividing rate code (/2, /3, /4) and every selector, both converters
        for (int k = 0; k < 4; k++) begin
            wr(32'h00, {24'h0, 1'b0, 2'(k % 3 + 1), 2'(k), 3'h0});
            wr(32'h04, {24'h0, 2'(k % 3 + 1), 2'(k), 4'h0});
            repeat (2) @(posedge aclk);
            // 12 clocks hold a whole number of periods for /2, /3 and /4
            count_done(12);
            `CHK(nd, 8'(12 / (k % 3 + 2)))
            `CHK(wd, 8'(12 / (k % 3 + 2)))
            chkrd(32'h00, {1'b1, 2'(k % 3 + 1), 2'(k), narrow_ain[3*k +: 3]}, 2'h0);
            chkrd(32'h04, {2'(k % 3 + 1), 2'(k), wide_ain[4*k +: 4]}, 2'h0);
        end
        // stop first, so no conversion races the data write
        wr(32'h00, 32'h10);
        wr(32'h00, 32'h12);
        narrow_ain <= 12'h000;
        count_done(10);
        `CHK({nd, wd}, {8'h00, 8'h05})
        chkrd(32'h00, 8'h92, 2'h0);
        wr(32'h0C, 32'hFF);
        `CHK(rs, 2'h2)
        chkrd(32'h0C, 8'h00, 2'h2);
        // lane 0 strobe off: answered, nothing stored
        s_axi_wstrb <= 4'hE;
        wr(32'h20, 32'hFF);
        `CHK(rs, 2'h0)
        chkrd(32'h20, 8'h14, 2'h0);
        test_done;
    end
    initial begin
        repeat (5000) @(posedge aclk);
        fail_count++;
        test_done;
    end
endmodule
`default_nettype wire
